// [rtl/art_timer.sv]
// Auto-reload timer core: counter, modes, PWM output and event flags
`timescale 1ns/1ps
module art_timer (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      timer_input_pin,
  input  wire logic                      count_enable_bit,
  input  wire logic                      load_bit,
  input  wire logic                      pwm_output_enable,
  input  wire logic [1:0]                mode_select,
  input  wire logic [1:0]                clock_select,
  input  wire logic [art_pkg::TAP_W-1:0] tap_select,
  input  wire logic                      edge_detect_enable,
  input  wire logic                      edge_polarity_select,
  input  wire logic                      overflow_irq_enable,
  input  wire logic                      compare_irq_enable,
  input  wire logic                      external_irq_enable,
  input  wire logic                      load_wr,
  input  wire logic [art_pkg::CNT_W-1:0] load_wdata,
  input  wire logic                      reload_wr,
  input  wire logic [art_pkg::CNT_W-1:0] reload_wdata,
  input  wire logic                      compare_wr,
  input  wire logic [art_pkg::CNT_W-1:0] compare_wdata,
  input  wire logic                      flag_wr,
  input  wire logic [art_pkg::FLAG_W-1:0] flag_wdata,
  output logic [art_pkg::CNT_W-1:0]      load_rdata,
  output logic [art_pkg::CNT_W-1:0]      reload_capture_rdata,
  output logic [art_pkg::CNT_W-1:0]      compare_rdata,
  output logic [art_pkg::FLAG_W-1:0]     event_flag_reg,
  output logic                           irq_req,
  output logic                           wake_wait,
  output logic                           wake_stop,
  output logic                           pwm_output_pin
);
  import art_pkg::*;

  art_tick_if tk ();

  logic [CNT_W-1:0]  up_counter_q;
  logic [CNT_W-1:0]  up_counter_d;
  logic [CNT_W-1:0]  reload_capture_reg_q;
  logic [CNT_W-1:0]  compare_reg_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flag_set;
  logic [1:0]        div3_q;
  logic              pwm_q;
  logic              irq_q;
  logic              wake_wait_q;
  logic              wake_stop_q;

  logic              pin_rise;
  logic              pin_fall;
  logic              active_edge;
  art_mode_e         mode;
  art_clk_e          clk_src;
  logic              capture_ev;
  logic              cap_reset;
  logic              ext_load;
  logic              any_load;
  logic              tick;
  logic              ovf_ev;
  logic              cmp_ev;
  logic [CNT_W-1:0]  inc_val;

  art_pin_sync i_art_pin_sync (
    .clk  (clk),
    .rst  (rst),
    .pin  (timer_input_pin),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  art_prescaler i_art_prescaler (
    .clk (clk),
    .rst (rst),
    .tk  (tk.pre)
  );

  assign mode    = art_mode_e'(mode_select);
  assign clk_src = art_clk_e'(clock_select);

  // Divide-by-three source; frozen with the counter so restarts are clean
  always_ff @(posedge clk) begin
    if (rst) begin
      div3_q <= 2'h0;
    end else if (count_enable_bit) begin
      div3_q <= (div3_q == DIV3_LAST) ? 2'h0 : div3_q + 2'h1;
    end
  end

  always_comb begin
    case (clk_src)
      ART_CLK_INT:      tk.src_tick = 1'b1;
      ART_CLK_INT_DIV3: tk.src_tick = (div3_q == DIV3_LAST);
      ART_CLK_PIN:      tk.src_tick = pin_rise;
      default:          tk.src_tick = 1'b0;
    endcase
  end

  assign active_edge = edge_detect_enable && (edge_polarity_select ? pin_fall : pin_rise);

  always_comb begin
    capture_ev = 1'b0;
    cap_reset  = 1'b0;
    ext_load   = 1'b0;
    case (mode)
      ART_MODE_CAPTURE:   capture_ev = active_edge;
      ART_MODE_CAP_RESET: begin
        capture_ev = active_edge;
        cap_reset  = active_edge;
      end
      ART_MODE_EXT_LOAD:  ext_load = active_edge;
      default:            capture_ev = 1'b0;
    endcase
  end

  // Software and edge loads win over counting; a load swallows the
  // overflow or match of the same cycle, so no stale event fires
  assign any_load = load_wr || ext_load || cap_reset || load_bit;
  assign tick     = tk.cnt_tick;

  // Overflow and match looked at only on an increment, once each
  always_comb begin
    ovf_ev = tick && !any_load && (up_counter_q == CNT_TOP);
    if (ovf_ev && mode == ART_MODE_RELOAD) begin
      inc_val = reload_capture_reg_q;
    end else begin
      inc_val = up_counter_q + 8'h01;
    end
    cmp_ev = tick && !any_load && (inc_val == compare_reg_q);
  end

  assign tk.run   = count_enable_bit;
  assign tk.tap   = tap_select;
  assign tk.clear = any_load || (ovf_ev && mode == ART_MODE_RELOAD);

  always_comb begin
    if (load_wr) begin
      up_counter_d = load_wdata;
    end else if (ext_load) begin
      up_counter_d = reload_capture_reg_q;
    end else if (cap_reset) begin
      up_counter_d = CNT_RST;
    end else if (load_bit) begin
      up_counter_d = reload_capture_reg_q;
    end else if (tick) begin
      up_counter_d = inc_val;
    end else begin
      up_counter_d = up_counter_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      up_counter_q <= CNT_RST;
    end else begin
      up_counter_q <= up_counter_d;
    end
  end

  // Capture beats a software write landing in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_capture_reg_q <= RELOAD_RST;
    end else if (capture_ev) begin
      reload_capture_reg_q <= up_counter_q;
    end else if (reload_wr) begin
      reload_capture_reg_q <= reload_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compare_reg_q <= CMP_RST;
    end else if (compare_wr) begin
      compare_reg_q <= compare_wdata;
    end
  end

  // Overflow sets the output, match clears it, in every mode
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else if (cmp_ev) begin
      pwm_q <= 1'b0;
    end else if (ovf_ev) begin
      pwm_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_output_pin <= 1'b0;
    end else begin
      pwm_output_pin <= pwm_output_enable && (cmp_ev ? 1'b0 : (ovf_ev ? 1'b1 : pwm_q));
    end
  end

  assign flag_set[FLAG_OVF] = ovf_ev;
  assign flag_set[FLAG_CMP] = cmp_ev;
  assign flag_set[FLAG_EXT] = active_edge;

  // Set wins over a clear in the same cycle so no event is lost
  generate
    for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (rst) begin
          flags_q[i] <= FLAG_RST[i];
        end else if (flag_set[i]) begin
          flags_q[i] <= 1'b1;
        end else if (flag_wr && !flag_wdata[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q       <= 1'b0;
      wake_wait_q <= 1'b0;
      wake_stop_q <= 1'b0;
    end else begin
      irq_q <= (flags_q[FLAG_OVF] && overflow_irq_enable)
            || (flags_q[FLAG_CMP] && compare_irq_enable)
            || (flags_q[FLAG_EXT] && external_irq_enable);
      wake_wait_q <= irq_q;
      // Stop halts the internal clock, so only a pin-clocked timer may wake it
      wake_stop_q <= irq_q && (clk_src == ART_CLK_PIN);
    end
  end

  assign load_rdata           = up_counter_q;
  assign reload_capture_rdata = reload_capture_reg_q;
  assign compare_rdata        = compare_reg_q;
  assign event_flag_reg       = flags_q;
  assign irq_req              = irq_q;
  assign wake_wait            = wake_wait_q;
  assign wake_stop            = wake_stop_q;

  chk_reset_clears_count: assert property (@(posedge clk)
    rst |=> up_counter_q == CNT_RST) else $error("counter not cleared by reset");
  chk_load_write_value: assert property (@(posedge clk) disable iff (rst)
    load_wr |=> up_counter_q == $past(load_wdata)) else $error("load write not placed in counter");
  chk_freeze_stopped: assert property (@(posedge clk) disable iff (rst)
    !count_enable_bit && !any_load |=> $stable(up_counter_q)) else $error("counter moved while stopped");
  chk_auto_reload: assert property (@(posedge clk) disable iff (rst)
    ovf_ev && mode == ART_MODE_RELOAD |=> up_counter_q == $past(reload_capture_reg_q))
    else $error("overflow did not reload counter");
  chk_overflow_flag: assert property (@(posedge clk) disable iff (rst)
    ovf_ev |=> flags_q[FLAG_OVF] ##1 (flags_q[FLAG_OVF] || $past(flag_wr)))
    else $error("overflow flag not set or not sticky");
  chk_compare_low: assert property (@(posedge clk) disable iff (rst)
    cmp_ev |=> !pwm_output_pin && flags_q[FLAG_CMP]) else $error("match did not clear output");
  chk_overflow_high: assert property (@(posedge clk) disable iff (rst)
    ovf_ev && !cmp_ev && pwm_output_enable |=> pwm_output_pin) else $error("overflow did not set output");
  chk_capture_copy: assert property (@(posedge clk) disable iff (rst)
    capture_ev |=> reload_capture_reg_q == $past(up_counter_q) && flags_q[FLAG_EXT])
    else $error("capture did not copy counter");
  chk_ext_edge_load: assert property (@(posedge clk) disable iff (rst)
    ext_load && !load_wr |=> up_counter_q == $past(reload_capture_reg_q))
    else $error("edge did not load counter");
  chk_flag_write_one: assert property (@(posedge clk) disable iff (rst)
    flag_wr && (&flag_wdata) |=> flags_q == ($past(flags_q) | $past(flag_set)))
    else $error("writing one changed a flag");
endmodule : art_timer

// [include/art_pkg.sv]
// Constants, types and mode codes shared by the auto-reload timer files
// Notes on behaviour
// - Eight-bit up-counter advances on prescaler ticks
// - Source mux: internal, internal/3, input pin
// - Seven-bit prescaler, eight taps, divide 2^n
// - Count-enable low freezes prescaler and counter
// - System reset clears the counter
// - Load register write places value immediately
// - Load register read returns live counter
// - Every counter load also clears prescaler
// - Auto-reload overflow reloads counter, sets output
// - Compare match in auto-reload clears output
// - Overflow sets sticky flag, optional interrupt
// - Compare match sets sticky flag, optional interrupt
// - Capture modes copy counter on active edge
// - Capture mode: free run, PWM, compare flag
// - Capture-with-reset also clears counter and prescaler
// - External-load mode loads reload on edge
// - External-load mode: overflow sets, compare clears
// - Events wake wait; stop only with pin clock
// - Mode codes: reload, capture, capture-reset, ext-load
// - Edge enable and polarity select detection
// - Clock select codes 00, 01, 10, 11 reserved
// - Writing zero clears a flag, one keeps
package art_pkg;
  localparam int CNT_W  = 8;
  localparam int PRE_W  = 7;
  localparam int TAP_W  = 3;
  localparam int FLAG_W = 3;

  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP = 1;
  localparam int FLAG_EXT = 2;

  localparam logic [CNT_W-1:0]  CNT_RST   = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_TOP   = 8'hff;
  localparam logic [CNT_W-1:0]  RELOAD_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CMP_RST   = 8'h00;
  localparam logic [PRE_W-1:0]  PRE_RST   = 7'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST  = 3'h0;
  localparam logic [1:0]        DIV3_LAST = 2'h2;

  typedef enum logic [1:0] {
    ART_MODE_RELOAD,
    ART_MODE_CAPTURE,
    ART_MODE_CAP_RESET,
    ART_MODE_EXT_LOAD
  } art_mode_e;

  typedef enum logic [1:0] {
    ART_CLK_INT,
    ART_CLK_INT_DIV3,
    ART_CLK_PIN,
    ART_CLK_RESERVED
  } art_clk_e;
endpackage : art_pkg

// [include/art_tick_if.sv]
// Tick path between the timer core and its prescaler
`timescale 1ns/1ps
interface art_tick_if;
  logic                     src_tick;
  logic                     run;
  logic                     clear;
  logic [art_pkg::TAP_W-1:0] tap;
  logic                     cnt_tick;

  modport pre  (input src_tick, input run, input clear, input tap, output cnt_tick);
  modport core (output src_tick, output run, output clear, output tap, input cnt_tick);
endinterface : art_tick_if

// [rtl/art_prescaler.sv]
// Seven-bit tapped prescaler for the auto-reload timer
`timescale 1ns/1ps
module art_prescaler (
  input wire logic clk,
  input wire logic rst,
  art_tick_if.pre  tk
);
  import art_pkg::*;

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] mask;

  // Tap n fires when the low n bits are about to wrap: divide by 2^n
  // Not gated by clear: reload clear is made from this tick, a loop otherwise
  always_comb begin
    mask        = 7'((8'h01 << tk.tap) - 8'h01);
    tk.cnt_tick = tk.run && tk.src_tick && ((pre_q & mask) == mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= PRE_RST;
    end else if (tk.clear) begin
      pre_q <= PRE_RST;
    end else if (tk.run && tk.src_tick) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  chk_pre_clear_zero: assert property (@(posedge clk) disable iff (rst)
    tk.clear |=> pre_q == PRE_RST) else $error("prescaler not cleared on load");
  chk_pre_hold_stop: assert property (@(posedge clk) disable iff (rst)
    !tk.run && !tk.clear |=> $stable(pre_q)) else $error("prescaler moved while stopped");
endmodule : art_prescaler

// [rtl/art_pin_sync.sv]
// Input pin synchroniser with edge detection
`timescale 1ns/1ps
module art_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Only sync_q and prev_q feed the edge logic; meta_q is never read elsewhere
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q && !prev_q;
  assign fall = !sync_q && prev_q;
endmodule : art_pin_sync

// [tb/art_ext_src.sv]
// Far-side stand-in: drives the timer input pin and loads the PWM output
`timescale 1ns/1ps
module art_ext_src (
  input  wire logic clk,
  input  wire logic pwm,
  output logic      pin
);
  int   pwm_rises;
  logic pwm_q;

  initial begin
    pin = 1'b0;
    pwm_rises = 0;
    pwm_q = 1'b0;
  end

  // Load side only counts pulses, never drives back
  always @(posedge clk) begin
    if (pwm === 1'b1 && pwm_q === 1'b0) begin
      pwm_rises++;
    end
    pwm_q <= pwm;
  end

  // Pin moves away from the sampling edge
  task automatic drive(input logic v);
    @(negedge clk);
    pin = v;
  endtask : drive
endmodule : art_ext_src

// [tb/art_timer_bench.sv]
// Self-checking bench for the auto-reload timer
`timescale 1ns/1ps
module art_timer_bench;
  import art_pkg::*;
  logic       clk, rst, pin, cen, ld_bit, pwm_oe, edge_en, edge_pol, ov_ie, cp_ie, ex_ie;
  logic       load_wr, reload_wr, compare_wr, flag_wr, irq_req, wake_wait, wake_stop, pwm;
  logic [1:0] mode, clk_sel;
  logic [2:0] tap, flag_wdata, flags;
  logic [7:0] wdata, cnt, cap, cmp;
  int         err_count;
  int         comparisons;

  art_timer i_art_timer (
    .clk(clk), .rst(rst), .timer_input_pin(pin), .count_enable_bit(cen), .load_bit(ld_bit),
    .pwm_output_enable(pwm_oe), .mode_select(mode), .clock_select(clk_sel), .tap_select(tap),
    .edge_detect_enable(edge_en), .edge_polarity_select(edge_pol), .overflow_irq_enable(ov_ie),
    .compare_irq_enable(cp_ie), .external_irq_enable(ex_ie), .load_wr(load_wr), .load_wdata(wdata),
    .reload_wr(reload_wr), .reload_wdata(wdata), .compare_wr(compare_wr), .compare_wdata(wdata),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata), .load_rdata(cnt), .reload_capture_rdata(cap),
    .compare_rdata(cmp), .event_flag_reg(flags), .irq_req(irq_req), .wake_wait(wake_wait),
    .wake_stop(wake_stop), .pwm_output_pin(pwm)
  );

  art_ext_src i_art_ext_src (.clk(clk), .pwm(pwm), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  // Strobe held for exactly one edge, then one edge for readback
  task automatic wr(input int sel, input logic [7:0] v);
    @(negedge clk);
    {ld_bit, flag_wr, compare_wr, reload_wr, load_wr} = 5'h01 << sel;
    wdata = v;
    flag_wdata = v[2:0];
    @(negedge clk);
    {ld_bit, flag_wr, compare_wr, reload_wr, load_wr} = 5'h00;
    @(negedge clk);
  endtask : wr

  task automatic wait_flag(input int idx);
    for (int i = 0; i < 600; i++) begin
      @(negedge clk);
      if (flags[idx] === 1'b1) return;
    end
    err_count++;
    $display("wrong value at %0t: flag %0d never set", $time, idx);
    stop_test();
  endtask : wait_flag

  // Synchroniser latency is two clocks, five leaves margin
  task automatic edge_to(input logic v);
    i_art_ext_src.drive(v);
    repeat (5) @(negedge clk);
  endtask : edge_to

  task automatic rate(input logic [1:0] cs, input logic [2:0] tp, input int n, input logic [7:0] exp);
    logic [7:0] a;
    @(negedge clk);
    clk_sel = cs;
    tap = tp;
    cen = 1'b1;
    repeat (3) @(negedge clk);
    a = cnt;
    repeat (n) @(negedge clk);
    check(8'(cnt - a), exp, "count rate");
    cen = 1'b0;
  endtask : rate

  task automatic t_reset;
    check(cnt, 8'h00, "counter after reset");
    check({cap[6:0], pwm}, 8'h00, "reload and pin after reset");
    check({cmp[6:0], flags[0]}, 8'h00, "compare and flag after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_load;
    wr(0, 8'h10);
    check(cnt, 8'h10, "load write");
    repeat (5) @(negedge clk);
    check(cnt, 8'h10, "frozen counter");
    wr(1, 8'h33);
    wr(4, 8'h00);
    check(cnt, 8'h33, "load bit");
    rate(2'h0, 3'h0, 8, 8'h08);
    rate(2'h0, 3'h2, 16, 8'h04);
    rate(2'h0, 3'h7, 256, 8'h02);
    rate(2'h1, 3'h0, 9, 8'h03);
    rate(2'h3, 3'h0, 9, 8'h00);
    clk_sel = 2'h0;
    $display("test load and rate done");
  endtask : t_load

  task automatic t_reload;
    mode = ART_MODE_RELOAD;
    wr(1, 8'hf0);
    wr(2, 8'hf8);
    wr(3, 8'h00);
    wr(0, 8'hfc);
    cen = 1'b1;
    wait_flag(0);
    check(cnt, 8'hf0, "reload on overflow");
    check(8'(pwm), 8'h01, "pin set on overflow");
    @(negedge clk);
    check(8'(irq_req), 8'h01, "overflow irq");
    @(negedge clk);
    check({wake_wait, wake_stop}, 8'h02, "wait wake only");
    wait_flag(1);
    check(cnt, 8'hf8, "compare match count");
    check(8'(pwm), 8'h00, "pin cleared on match");
    cen = 1'b0;
    check(8'(i_art_ext_src.pwm_rises), 8'h01, "single pwm pulse");
    wr(3, 8'h06);
    check(8'(flags), 8'h02, "overflow flag cleared only");
    wr(3, 8'h00);
    $display("test auto-reload done");
  endtask : t_reload

  task automatic t_capture;
    mode = ART_MODE_CAPTURE;
    clk_sel = 2'h0;
    edge_en = 1'b1;
    edge_pol = 1'b0;
    ex_ie = 1'b1;
    wr(0, 8'h55);
    edge_to(1'b1);
    check(cap, 8'h55, "capture on rise");
    check({flags, irq_req}, 8'h09, "ext flag and irq");
    wr(0, 8'h66);
    edge_to(1'b0);
    check(cap, 8'h55, "fall ignored");
    edge_pol = 1'b1;
    edge_to(1'b1);
    check(cap, 8'h55, "rise ignored");
    edge_to(1'b0);
    check(cap, 8'h66, "capture on fall");
    edge_en = 1'b0;
    wr(0, 8'h77);
    edge_to(1'b1);
    edge_to(1'b0);
    check(cap, 8'h66, "detection off");
    $display("test capture done");
  endtask : t_capture

  task automatic t_modes;
    mode = ART_MODE_CAP_RESET;
    edge_en = 1'b1;
    edge_pol = 1'b0;
    wr(0, 8'h44);
    edge_to(1'b1);
    check(cap, 8'h44, "capture with reset");
    check(cnt, 8'h00, "counter reset by capture");
    mode = ART_MODE_EXT_LOAD;
    wr(1, 8'h99);
    wr(0, 8'h11);
    edge_to(1'b0);
    check(cnt, 8'h11, "no load on fall");
    edge_to(1'b1);
    check(cnt, 8'h99, "load on edge");
    $display("test capture-reset and edge-load done");
  endtask : t_modes

  task automatic t_pin_clock;
    mode = ART_MODE_RELOAD;
    edge_en = 1'b0;
    clk_sel = 2'h2;
    cen = 1'b1;
    edge_to(1'b0);
    edge_to(1'b1);
    edge_to(1'b0);
    edge_to(1'b1);
    check(cnt, 8'h9b, "pin clock count");
    check({wake_wait, wake_stop}, 8'h03, "stop wake on pin clock");
    cen = 1'b0;
    clk_sel = 2'h0;
    $display("test pin clock done");
  endtask : t_pin_clock

  task automatic t_free_run;
    mode = ART_MODE_CAPTURE;
    {ov_ie, ex_ie} = 2'h0;
    cp_ie = 1'b1;
    wr(3, 8'h00);
    wr(2, 8'h03);
    wr(0, 8'hfe);
    cen = 1'b1;
    wait_flag(0);
    check(cnt, 8'h00, "free run past top");
    check({pwm, irq_req}, 8'h02, "overflow sets pin, irq masked");
    pwm_oe = 1'b0;
    @(negedge clk);
    check(8'(pwm), 8'h00, "pin low while disabled");
    pwm_oe = 1'b1;
    wait_flag(1);
    cen = 1'b0;
    check(cnt, 8'h03, "free run match count");
    check(8'(pwm), 8'h00, "match clears pin");
    @(negedge clk);
    check(8'(irq_req), 8'h01, "compare irq");
    wr(3, 8'h07);
    check(8'(flags), 8'h03, "writing ones keeps flags");
    wr(3, 8'h00);
    check(8'(flags), 8'h00, "writing zeros clears flags");
    $display("test free run done");
  endtask : t_free_run

  initial begin
    err_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {cen, ld_bit, edge_en, edge_pol, ov_ie, cp_ie, ex_ie} = 7'h00;
    {load_wr, reload_wr, compare_wr, flag_wr} = 4'h0;
    pwm_oe = 1'b1;
    ov_ie = 1'b1;
    mode = 2'h0;
    clk_sel = 2'h0;
    tap = 3'h0;
    wdata = 8'h00;
    flag_wdata = 3'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_load();
    t_reload();
    t_capture();
    t_modes();
    t_pin_clock();
    t_free_run();
    stop_test();
  end
endmodule : art_timer_bench
